// ---- rvs_regs.vh ----
`ifndef RVS_REGS_VH
`define RVS_REGS_VH
// APB register byte offsets
`define RVS_OFF_CTRL      12'h000
`define RVS_OFF_STATUS    12'h004
`define RVS_OFF_VEC_ADDR  12'h008
`define RVS_OFF_ENTRY     12'h00C
`define RVS_OFF_RDATA     12'h010
// Control fields
`define RVS_CTRL_REDUCED  0
// Status fields
`define RVS_ST_DONE       0
`define RVS_ST_BOOT       1
`define RVS_ST_BUS        2
`define RVS_ST_SEL_LO     3
`define RVS_ST_ERR        5
`define RVS_ST_FLAGS      6
// Vector locations
`define RVS_VEC_00        32'h0000_0000
`define RVS_VEC_01        32'h7FFF_FFFF
`define RVS_VEC_10        32'h8000_0000
`define RVS_VEC_11        32'hFFFF_FFFF
// Least reset hold in phase-one cycles
`define RVS_RST_MIN_CYC   4'hA
`endif

// ---- rvs_reset_vector_select.v ----
// Behaviour
// - After reset release, read word at vector location and start execution at the address it holds.
// - Select pins sampled in reset: 00 local 0000_0000, 01 local 7FFF_FFFF.
// - Code 10 global 8000_0000, code 11 global FFFF_FFFF; full 32-bit addresses.
// - Boot mode: device supplies vector to on-chip bootloader start itself.
// - Reduced-pin variant drives only low 24 address bits on both buses.
`timescale 1ns/1ps
`include "rvs_regs.vh"
module rvs_reset_vector_select #(
  parameter [31:0] BOOT_VECTOR = 32'h0000_1000,
  parameter        REDUCED_PIN = 1'b0
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        core_rst_n,
  input  wire [1:0]  vector_select_pins,
  input  wire        boot_rom_enable,
  input  wire [3:0]  int_flag_pins,
  output reg  [31:0] global_addr_pins,
  output reg  [31:0] local_addr_pins,
  output reg         global_strobe_n,
  output reg  [1:0]  local_bus_strobes_n,
  input  wire [31:0] mem_rdata,
  input  wire        mem_ready,
  output reg  [31:0] exec_start_addr,
  output reg         exec_start
);

  // ****************************************
  // State encoding and storage
  // ****************************************
  localparam [3:0] ST_RESET = 4'b0001;
  localparam [3:0] ST_FETCH = 4'b0010;
  localparam [3:0] ST_RUN   = 4'b0100;
  localparam [3:0] ST_WAIT  = 4'b1000;

  reg  [3:0]  state_q;
  reg  [1:0]  sel_q;
  reg         boot_q;
  reg  [3:0]  hold_cnt_q;
  reg         short_err_q;
  reg  [31:0] vec_addr_q;
  reg  [31:0] rdata_q;
  reg         reduced_q;
  reg  [3:0]  flags_q;
  reg  [31:0] vec_addr_d;
  reg  [31:0] status_word;
  reg  [31:0] rd_mux;
  reg         addr_hit;
  wire [31:0] pin_addr;
  wire        hold_met;
  wire        fetch_on;

  // ****************************************
  // Vector table
  // ****************************************
  // Full 32-bit addresses; the pin drive trims them on reduced-pin parts
  always @* begin
    case (sel_q)
      2'b00:   vec_addr_d = `RVS_VEC_00;
      2'b01:   vec_addr_d = `RVS_VEC_01;
      2'b10:   vec_addr_d = `RVS_VEC_10;
      default: vec_addr_d = `RVS_VEC_11;
    endcase
  end

  // ****************************************
  // Reset hold counter
  // ****************************************
  // The edge that drops back into reset already sees the pin low, so it counts as one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 4'h0;
    end else if (!core_rst_n && state_q != ST_RESET) begin
      hold_cnt_q <= 4'h1;
    end else if (state_q == ST_RESET && !hold_met) begin
      hold_cnt_q <= hold_cnt_q + 4'h1;
    end
  end

  assign hold_met = (hold_cnt_q == `RVS_RST_MIN_CYC);
  assign fetch_on = !global_strobe_n || (local_bus_strobes_n == 2'b00);

  // ****************************************
  // Fetch sequencer
  // ****************************************
  // Reduced-pin parts drive the top byte as zero (low)
  assign pin_addr = (reduced_q | REDUCED_PIN) ? {8'h00, vec_addr_q[23:0]} : vec_addr_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q             <= ST_RESET;
      sel_q               <= 2'b00;
      boot_q              <= 1'b0;
      short_err_q         <= 1'b0;
      vec_addr_q          <= 32'h0000_0000;
      rdata_q             <= 32'h0000_0000;
      flags_q             <= 4'h0;
      global_addr_pins    <= 32'h0000_0000;
      local_addr_pins     <= 32'h0000_0000;
      global_strobe_n     <= 1'b1;
      local_bus_strobes_n <= 2'b11;
      exec_start_addr     <= 32'h0000_0000;
      exec_start          <= 1'b0;
    end else begin
      exec_start <= 1'b0;
      case (state_q)
        ST_RESET: begin
          // Pins follow while core reset is low; frozen at release
          sel_q   <= vector_select_pins;
          boot_q  <= boot_rom_enable;
          flags_q <= int_flag_pins;
          if (core_rst_n) begin
            // Short pulse is flagged, fetch still proceeds
            short_err_q <= !hold_met;
            state_q     <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          vec_addr_q <= vec_addr_d;
          if (boot_q) begin
            // Bootloader vector is internal; no bus cycle
            exec_start_addr <= BOOT_VECTOR;
            exec_start      <= 1'b1;
            state_q         <= ST_RUN;
          end else begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (sel_q[1]) begin
            global_addr_pins <= pin_addr;
            global_strobe_n  <= 1'b0;
          end else begin
            local_addr_pins     <= pin_addr;
            local_bus_strobes_n <= 2'b00;
          end
          if (mem_ready && fetch_on) begin
            rdata_q             <= mem_rdata;
            exec_start_addr     <= mem_rdata;
            exec_start          <= 1'b1;
            global_strobe_n     <= 1'b1;
            local_bus_strobes_n <= 2'b11;
            state_q             <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!core_rst_n)
            state_q <= ST_RESET;
        end
        default: state_q <= ST_RESET;
      endcase
      if (!core_rst_n && state_q != ST_RESET) begin
        global_strobe_n     <= 1'b1;
        local_bus_strobes_n <= 2'b11;
        state_q             <= ST_RESET;
      end
    end
  end

  // ****************************************
  // Status word and read decode
  // ****************************************
  always @* begin
    status_word                      = 32'h0000_0000;
    status_word[`RVS_ST_DONE]        = (state_q == ST_RUN);
    status_word[`RVS_ST_BOOT]        = boot_q;
    status_word[`RVS_ST_BUS]         = sel_q[1];
    status_word[`RVS_ST_SEL_LO +: 2] = sel_q;
    status_word[`RVS_ST_ERR]         = short_err_q;
    status_word[`RVS_ST_FLAGS +: 4]  = flags_q;
  end

  // Unmapped offsets read as zero and answer with an error
  always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      `RVS_OFF_CTRL:     rd_mux = {31'h0, reduced_q};
      `RVS_OFF_STATUS:   rd_mux = status_word;
      `RVS_OFF_VEC_ADDR: rd_mux = vec_addr_q;
      `RVS_OFF_ENTRY:    rd_mux = exec_start_addr;
      `RVS_OFF_RDATA:    rd_mux = rdata_q;
      default:           addr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // APB register slave
  // ****************************************
  // One wait state: pready rises the cycle after the access phase is seen
  wire apb_acc = psel & penable & ~pready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reduced_q <= 1'b0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~addr_hit;
      if (apb_acc) begin
        prdata <= rd_mux;
        if (pwrite && paddr == `RVS_OFF_CTRL)
          reduced_q <= pwdata[`RVS_CTRL_REDUCED];
      end
    end
  end

endmodule // rvs_reset_vector_select

// ---- rvs_asserts.sv ----
`timescale 1ns/1ps
module rvs_asserts #(parameter [31:0] BOOT_VECTOR = 32'h0000_1000) (
  input wire        pclk, presetn, core_rst_n, boot_rom_enable, global_strobe_n, mem_ready, exec_start,
  input wire [1:0]  vector_select_pins, local_bus_strobes_n,
  input wire [31:0] global_addr_pins, local_addr_pins, mem_rdata, exec_start_addr);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Low 24 bits only, so the checks hold in reduced-pin mode too
  wire fetch = !(global_strobe_n && local_bus_strobes_n[0]);
  property p_word; mem_ready && fetch |=> exec_start && exec_start_addr == $past(mem_rdata); endproperty
  a_word: assert property (p_word) else $error("start address differs from fetched word");
  property p_go; $rose(core_rst_n) && !boot_rom_enable |-> ##[1:3] fetch; endproperty
  a_go: assert property (p_go) else $error("no vector fetch after release");
  property p_loc; !local_bus_strobes_n[0] |-> !vector_select_pins[1] && local_addr_pins[23:0] == {24{vector_select_pins[0]}}; endproperty
  a_loc: assert property (p_loc) else $error("wrong local vector fetch");
  property p_glb; !global_strobe_n |-> vector_select_pins[1] && global_addr_pins[23:0] == {24{vector_select_pins[0]}}; endproperty
  a_glb: assert property (p_glb) else $error("wrong global vector fetch");
  property p_boot; $rose(core_rst_n) && boot_rom_enable |-> ##[1:3] exec_start && exec_start_addr == BOOT_VECTOR; endproperty
  a_boot: assert property (p_boot) else $error("boot vector not taken");
  property p_pair; local_bus_strobes_n[0] == local_bus_strobes_n[1]; endproperty
  a_pair: assert property (p_pair) else $error("local strobes split");
  property p_held; !core_rst_n [*3] |-> !fetch && !exec_start; endproperty
  a_held: assert property (p_held) else $error("activity while reset held");
  c_ext: cover property (mem_ready && fetch);
  c_boot: cover property ($rose(core_rst_n) && boot_rom_enable);
  c_glb: cover property (!global_strobe_n && vector_select_pins == 2'b11);
endmodule // rvs_asserts

// ---- rvs_mem_model.sv ----
`timescale 1ns/1ps
module rvs_mem_model (
  input wire        pclk, global_strobe_n,
  input wire [1:0]  local_bus_strobes_n,
  input wire [31:0] global_addr_pins, local_addr_pins,
  input wire [3:0]  wait_cyc,
  output reg [31:0] mem_rdata,
  output reg        mem_ready);
  reg [3:0] cnt_q;
  wire act = !(global_strobe_n && local_bus_strobes_n[0]);
  wire hit = act && !mem_ready && cnt_q >= wait_cyc;
  initial {cnt_q, mem_ready, mem_rdata} = 0;
  always @(posedge pclk) begin
    cnt_q <= (act && !mem_ready) ? cnt_q + 4'h1 : 4'h0;
    mem_ready <= hit;
    // Stale data is inverted each cycle so a sample one cycle late never matches
    mem_rdata <= hit ? (global_strobe_n ? local_addr_pins : global_addr_pins) ^ 32'h5A5A_0F0F : ~mem_rdata;
  end
endmodule // rvs_mem_model

// ---- reset_vector_select_bench.sv ----
`timescale 1ns/1ps
module reset_vector_select_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, core_rst_n = 0, boot_rom_enable = 0, er;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000, rd;
  reg  [1:0]  vector_select_pins = 2'b00;
  reg  [3:0]  int_flag_pins = 4'h0, wait_cyc = 4'h0;
  wire [31:0] prdata, global_addr_pins, local_addr_pins, mem_rdata, exec_start_addr;
  wire        pready, pslverr, global_strobe_n, mem_ready, exec_start;
  wire [1:0]  local_bus_strobes_n;
  integer     err_count = 0, compares = 0, i;
  always #2 pclk = ~pclk;
  rvs_reset_vector_select #(.BOOT_VECTOR(32'h0000_2A40)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_rst_n, .vector_select_pins, .boot_rom_enable, .int_flag_pins,
    .global_addr_pins, .local_addr_pins, .global_strobe_n, .local_bus_strobes_n, .mem_rdata, .mem_ready,
    .exec_start_addr, .exec_start);
  rvs_mem_model u_mem (.pclk, .global_strobe_n, .local_bus_strobes_n, .global_addr_pins, .local_addr_pins,
    .wait_cyc, .mem_rdata, .mem_ready);
  task complete_run; begin
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  task chk(input [31:0] got, input [31:0] exp); begin
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  end endtask
  task bound(input integer n); begin
    if (n >= 40) begin
      err_count = err_count + 1;
      $display("[ERR] %0t wait timed out", $time);
      complete_run;
    end
  end endtask
  task apb(input w, input [11:0] a, input [31:0] d); integer n; begin
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    n = 0;
    do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 40);
    bound(n);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  end endtask
  // Pins stay put after release until the next fetch, as the assertions expect
  task fetch(input [1:0] c, input b, input [4:0] h); integer n; begin
    @(posedge pclk); core_rst_n <= 0; vector_select_pins <= c; boot_rom_enable <= b;
    repeat (h) @(posedge pclk);
    core_rst_n <= 1;
    n = 0;
    do begin @(posedge pclk); n = n + 1; end while (exec_start !== 1'b1 && n < 40);
    bound(n);
    rd = exec_start_addr;
  end endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 4; i = i + 1) begin
      wait_cyc <= 4'h3 * i[3:0];
      fetch(i[1:0], 0, 12);
      chk(rd, {i[1], {31{i[0]}}} ^ 32'h5A5A_0F0F);
      apb(0, 12'h004, 0);
      chk(rd[5:0], {1'b0, i[1:0], i[1], 2'b01});
      $display("vector code %0d test done", i);
    end
    int_flag_pins <= 4'h9;
    fetch(2'b00, 1, 12);
    chk(rd, 32'h0000_2A40);
    apb(0, 12'h004, 0);
    chk(rd[9:0], {4'h9, 6'h03});
    $display("boot test done");
    fetch(2'b01, 0, 3);
    apb(0, 12'h004, 0);
    chk(rd[5], 1'b1);
    fetch(2'b01, 0, 10);
    apb(0, 12'h004, 0);
    chk(rd[5], 1'b0);
    fetch(2'b01, 0, 9);
    apb(0, 12'h004, 0);
    chk(rd[5], 1'b1);
    apb(1, 12'h000, 1);
    fetch(2'b11, 0, 12);
    chk(rd, 32'h00FF_FFFF ^ 32'h5A5A_0F0F);
    apb(0, 12'h008, 0);
    chk(rd, 32'hFFFF_FFFF);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h00FF_FFFF ^ 32'h5A5A_0F0F);
    apb(0, 12'h010, 0);
    chk(rd, 32'h00FF_FFFF ^ 32'h5A5A_0F0F);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_0001);
    fetch(2'b01, 0, 12);
    chk(rd, 32'h00FF_FFFF ^ 32'h5A5A_0F0F);
    apb(0, 12'h0FC, 0);
    chk(er, 1'b1);
    $display("short reset, reduced pin and unmapped tests done");
    complete_run;
  end
endmodule // reset_vector_select_bench
bind rvs_reset_vector_select rvs_asserts #(.BOOT_VECTOR(BOOT_VECTOR)) u_chk (.pclk, .presetn, .core_rst_n,
  .boot_rom_enable, .global_strobe_n, .mem_ready, .exec_start, .vector_select_pins, .local_bus_strobes_n,
  .global_addr_pins, .local_addr_pins, .mem_rdata, .exec_start_addr);
